// ==== hw/sacc_ctrl.sv ====
// What this block does
// - Channel field selects identical input number directly.
// - Conversion start preloads trial with MSB only.
// - Compare high keeps bit; else clears; next set.
// - Upper eight bits coarse tap, lower two fine.
// - Fine tap rises monotonically with low bits.
// - Scan mode advances channel every conversion unless a new start arrives in the done cycle.
// - Conversion end raises interrupt pulse.
`timescale 1ns/1ns
`include "sacc_params.svh"

module sacc_ctrl (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire sacc_pkg::sacc_cmd_t   cmd,
    input  wire logic                  cmp_high,
    output sacc_pkg::sacc_analog_t     analog,
    output sacc_pkg::sacc_result_t     result,
    output logic                       busy,
    output logic                       done_irq
);

    // Comparator output is asynchronous to sys_clk: three-stage synchroniser.
    logic       cmp_s1;
    logic       cmp_s2;
    logic       cmp_s3;
    logic       cmp_val;
    logic       next_cmp_val;

    always_comb begin
        next_cmp_val = (cmp_s2 == cmp_s3) ? cmp_s3 : cmp_val;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmp_s1  <= 1'b0;
            cmp_s2  <= 1'b0;
            cmp_s3  <= 1'b0;
            cmp_val <= 1'b0;
        end else begin
            cmp_s1  <= cmp_high;
            cmp_s2  <= cmp_s1;
            cmp_s3  <= cmp_s2;
            cmp_val <= next_cmp_val;
        end
    end

    // Next channel in scan order; wraps after the highest input.
    function automatic logic [3:0] next_chan(input logic [3:0] ch);
        next_chan = ch + `SACC_CH_ONE;
    endfunction

    sacc_pkg::sacc_state_t state;
    sacc_pkg::sacc_state_t next_state;
    logic [9:0]            trial;
    logic [9:0]            next_trial;
    logic [9:0]            bitmask;
    logic [9:0]            next_bitmask;
    logic [3:0]            step;
    logic [3:0]            next_step;
    logic [3:0]            wait_cnt;
    logic [3:0]            next_wait_cnt;
    logic [3:0]            chan;
    logic [3:0]            next_chan_r;
    logic                  scan;
    logic                  next_scan;
    sacc_pkg::sacc_result_t next_result;
    logic                  next_irq;

    // Sequencer: sample, ten trial steps, then publish and optionally rescan.
    always_comb begin
        next_state    = state;
        next_trial    = trial;
        next_bitmask  = bitmask;
        next_step     = step;
        next_wait_cnt = wait_cnt;
        next_chan_r   = chan;
        next_scan     = scan;
        next_result   = result;
        next_irq      = 1'b0;
        case (state)
            sacc_pkg::SACC_IDLE: begin
                // A start is taken here or in the done cycle; one during sample or trial is ignored.
                if (cmd.start) begin
                    next_chan_r   = cmd.channel;
                    next_scan     = cmd.scan;
                    next_wait_cnt = `SACC_STEP_ZERO;
                    next_state    = sacc_pkg::SACC_SAMPLE;
                end
            end
            sacc_pkg::SACC_SAMPLE: begin
                next_wait_cnt = wait_cnt + `SACC_STEP_ONE;
                if (wait_cnt == `SACC_SAMPLE_CYC) begin
                    // Restart the settle count so the first step is as long as the rest.
                    next_wait_cnt = `SACC_STEP_ZERO;
                    next_trial   = `SACC_MSB_ONLY;
                    next_bitmask = `SACC_MSB_ONLY;
                    next_step    = `SACC_STEP_ZERO;
                    next_state   = sacc_pkg::SACC_TRIAL;
                end
            end
            sacc_pkg::SACC_TRIAL: begin
                // Wait the synchroniser depth plus one before trusting the compare.
                next_wait_cnt = wait_cnt + `SACC_STEP_ONE;
                if (wait_cnt == `SACC_SETTLE_CYC) begin
                    next_wait_cnt = `SACC_STEP_ZERO;
                    // Decide the bit under test, then try the next lower one.
                    next_trial = cmp_val ? trial : (trial & ~bitmask);
                    next_trial = next_trial | (bitmask >> 1);
                    next_bitmask = bitmask >> 1;
                    next_step = step + `SACC_STEP_ONE;
                    if (step == `SACC_STEPS) begin
                        next_state = sacc_pkg::SACC_DONE;
                    end
                end
            end
            sacc_pkg::SACC_DONE: begin
                // Publish the code; a start here overrides scan, otherwise scan steps on.
                next_result.code    = trial;
                next_result.channel = chan;
                next_irq            = 1'b1;
                next_wait_cnt       = `SACC_STEP_ZERO;
                if (scan && !cmd.start) begin
                    next_chan_r = next_chan(chan);
                    next_state  = sacc_pkg::SACC_SAMPLE;
                end else if (cmd.start) begin
                    next_chan_r = cmd.channel;
                    next_scan   = cmd.scan;
                    next_state  = sacc_pkg::SACC_SAMPLE;
                end else begin
                    next_state = sacc_pkg::SACC_IDLE;
                end
            end
            default: begin
                next_state = sacc_pkg::SACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state    <= sacc_pkg::SACC_IDLE;
            trial    <= `SACC_RES_ZERO;
            bitmask  <= `SACC_RES_ZERO;
            step     <= `SACC_STEP_ZERO;
            wait_cnt <= `SACC_STEP_ZERO;
            chan     <= `SACC_CH_ZERO;
            scan     <= 1'b0;
            result   <= '0;
            done_irq <= 1'b0;
        end else begin
            state    <= next_state;
            trial    <= next_trial;
            bitmask  <= next_bitmask;
            step     <= next_step;
            wait_cnt <= next_wait_cnt;
            chan     <= next_chan_r;
            scan     <= next_scan;
            result   <= next_result;
            done_irq <= next_irq;
        end
    end

    // Ladder drive straight from the trial register; the fine tap is the plain
    // low bits so the summed voltage rises as they count up.
    assign analog.coarse_tap = trial[`SACC_COARSE_HI:`SACC_COARSE_LO];
    assign analog.fine_tap   = trial[`SACC_FINE_HI:`SACC_FINE_LO];
    assign analog.mux_sel    = chan;
    assign analog.sample     = (state == sacc_pkg::SACC_SAMPLE);
    assign busy              = (state != sacc_pkg::SACC_IDLE);

    // Checks: each one guards a rule of the search, next to the logic above.

    // A start in idle loads the written channel number unchanged.
    a_chan_direct: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sacc_pkg::SACC_IDLE && cmd.start) |=> (chan == $past(cmd.channel)))
        else $error("Channel not taken as written.");

    // Leaving the sample phase loads the trial with only the top bit set.
    a_preload_msb: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sacc_pkg::SACC_SAMPLE && next_state == sacc_pkg::SACC_TRIAL) |=> (trial == `SACC_MSB_ONLY))
        else $error("Trial not preloaded with MSB.");

    // A low compare clears the bit that was under test.
    a_search_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sacc_pkg::SACC_TRIAL && wait_cnt == `SACC_SETTLE_CYC && !cmp_val)
        |=> ((trial & $past(bitmask)) == `SACC_RES_ZERO))
        else $error("Low compare did not clear bit.");

    // The first trial sits on the middle coarse tap with no fine offset.
    a_tap_split: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sacc_pkg::SACC_SAMPLE && next_state == sacc_pkg::SACC_TRIAL)
        |=> (analog.coarse_tap == `SACC_COARSE_MID && analog.fine_tap == `SACC_FINE_ZERO))
        else $error("Ladder taps differ from trial.");

    // Keeping the second-lowest bit moves the fine tap exactly one step up.
    a_fine_mono: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sacc_pkg::SACC_TRIAL && wait_cnt == `SACC_SETTLE_CYC && cmp_val && bitmask == `SACC_FINE_BIT)
        |=> (analog.fine_tap == $past(analog.fine_tap) + `SACC_FINE_ONE))
        else $error("Fine tap order broken.");

    // Scan moves on to the next channel after every conversion whose done cycle sees no new start.
    a_scan_moves: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sacc_pkg::SACC_DONE && scan && !cmd.start) |=> (chan == $past(chan) + `SACC_CH_ONE))
        else $error("Scan did not advance channel.");

    // The done state is followed by exactly one interrupt pulse.
    a_irq_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sacc_pkg::SACC_DONE) |=> done_irq ##1 !done_irq)
        else $error("Done interrupt not one pulse.");

    // Ten steps of five cycles each separate the preload from the done state.
    a_ten_steps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sacc_pkg::SACC_SAMPLE && next_state == sacc_pkg::SACC_TRIAL)
        |=> (state == sacc_pkg::SACC_TRIAL) [*8] ##43 (state == sacc_pkg::SACC_DONE))
        else $error("Search length wrong.");

    // Main scenarios: single, scan, full scale, scan wrap and a restart in the done cycle.
    c_single:  cover property (@(posedge sys_clk) disable iff (!rst_n) done_irq && !scan);
    c_scan:    cover property (@(posedge sys_clk) disable iff (!rst_n) done_irq && scan);
    c_full:    cover property (@(posedge sys_clk) disable iff (!rst_n) done_irq && result.code == `SACC_RES_FULL);
    c_wrap:    cover property (@(posedge sys_clk) disable iff (!rst_n) done_irq && scan && result.channel == `SACC_CH_ZERO);
    c_restart: cover property (@(posedge sys_clk) disable iff (!rst_n) done_irq && busy && !scan);

endmodule

// ==== hw/sacc_params.svh ====
`ifndef SACC_PARAMS_SVH
`define SACC_PARAMS_SVH

// Result width and search geometry.
`define SACC_RES_W       10
`define SACC_CH_W        4
`define SACC_COARSE_W    8
`define SACC_FINE_W      2
`define SACC_MSB_ONLY    10'h200
`define SACC_RES_ZERO    10'h000
`define SACC_CH_ZERO     4'h0
`define SACC_CH_ONE      4'h1
`define SACC_STEPS       4'h9
`define SACC_STEP_ZERO   4'h0
`define SACC_STEP_ONE    4'h1
// Cycles the compare must stand before a decision: synchroniser depth plus one.
`define SACC_SETTLE_CYC  4'h4
// Split of the trial code between the coarse and the fine ladder taps.
`define SACC_COARSE_HI   9
`define SACC_COARSE_LO   2
`define SACC_FINE_HI     1
`define SACC_FINE_LO     0
`define SACC_COARSE_MID  8'h80
`define SACC_FINE_ZERO   2'h0
`define SACC_FINE_ONE    2'h1
`define SACC_FINE_BIT    10'h002
`define SACC_RES_FULL    10'h3ff
// Sample phase length in cycles: time in ns and derived count at 50 ns.
`define SACC_SAMPLE_NS   500
`define SACC_CLK_NS      50
`define SACC_SAMPLE_CYC  4'((`SACC_SAMPLE_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS)

`endif

// ==== hw/sacc_pkg.sv ====
package sacc_pkg;
    // Converter control states, one-hot.
    typedef enum logic [3:0] {
        SACC_IDLE   = 4'b0001,
        SACC_SAMPLE = 4'b0010,
        SACC_TRIAL  = 4'b0100,
        SACC_DONE   = 4'b1000
    } sacc_state_t;

    // Command from software: start pulse, channel and scan request.
    typedef struct packed {
        logic       start;
        logic       scan;
        logic [3:0] channel;
    } sacc_cmd_t;

    // Drive toward the analog ladder.
    typedef struct packed {
        logic [7:0] coarse_tap;
        logic [1:0] fine_tap;
        logic [3:0] mux_sel;
        logic       sample;
    } sacc_analog_t;

    // Finished conversion record.
    typedef struct packed {
        logic [9:0] code;
        logic [3:0] channel;
    } sacc_result_t;
endpackage

// ==== testbench/sacc_ladder_model.sv ====
`timescale 1ns/1ns
// Far side of the converter: the sampled input, the ladder taps and the comparator.
module sacc_ladder_model (
    input  wire logic                   sys_clk,
    input  wire sacc_pkg::sacc_analog_t analog,
    input  wire logic [15:0][9:0]       volts,
    output logic                        cmp_high
);
    logic [9:0] held = 10'h000;

    // The hold capacitor follows the selected input only while sampling.
    always @(posedge sys_clk) begin
        if (analog.sample) begin
            held <= volts[analog.mux_sel];
        end
    end

    // The input sits half a step above its code, so a correct search ends on that code.
    assign cmp_high = {held, 1'b1} > {analog.coarse_tap, analog.fine_tap, 1'b0};
endmodule

// ==== testbench/sar_adc_channel_control_bench.sv ====
`timescale 1ns/1ns
module sar_adc_channel_control_bench;
    logic                   sys_clk;
    logic                   rst_n;
    sacc_pkg::sacc_cmd_t    cmd;
    logic                   cmp_high;
    sacc_pkg::sacc_analog_t analog;
    sacc_pkg::sacc_result_t result;
    logic                   busy;
    logic                   done_irq;
    logic [15:0][9:0]       volts;
    logic [31:0]            seed;
    int                     mismatches;
    int                     n_checks;
    sacc_pkg::sacc_result_t expq[$];

    sacc_ctrl sacc_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd), .cmp_high(cmp_high),
        .analog(analog), .result(result), .busy(busy), .done_irq(done_irq));
    sacc_ladder_model sacc_ladder_model_inst (.sys_clk(sys_clk), .analog(analog), .volts(volts),
        .cmp_high(cmp_high));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Starts a conversion, notes n expected results, checks the first trial and waits for n ends.
    // With hold the start stays high into the done cycle, so the same channel runs once more.
    task automatic run(input logic [3:0] ch, input logic scan, input logic hold, input int n);
        int got;
        int t;
        got = 0;
        t = 0;
        for (int i = 0; i < n; i++) begin
            expq.push_back({volts[4'(ch + (scan ? i : 0))], 4'(ch + (scan ? i : 0))});
        end
        cmd = {1'b1, scan, ch};
        @(negedge sys_clk);
        cmd.start = hold;
        while (analog.sample !== 1'b0 && t < 30) begin
            @(negedge sys_clk);
            t++;
        end
        check("first trial", 32'({analog.coarse_tap, analog.fine_tap}), 32'h200);
        check("mux select", 32'(analog.mux_sel), 32'(ch));
        check("busy in search", 32'(busy), 32'h1);
        if (!scan && !hold) begin
            cmd = {1'b1, 1'b0, 4'(ch + 1)};
            @(negedge sys_clk);
            cmd.start = 1'b0;
        end
        while (got < n && t < 100 * n) begin
            @(negedge sys_clk);
            t++;
            if (done_irq === 1'b1) begin
                got++;
                cmd.start = 1'b0;
            end
        end
        check("conversion ends", 32'(got), 32'(n));
        check("busy after end", 32'(busy), 32'(scan));
        @(negedge sys_clk);
    endtask

    // Free-running system clock.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Cuts the run short if the conversions hang.
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        results();
    end

    // Takes the oldest noted result whenever the end-of-conversion pulse shows.
    always @(negedge sys_clk) begin
        if (done_irq === 1'b1) begin
            if (expq.size() == 0) begin
                check("unexpected done", 32'h1, 32'h0);
            end else begin
                check("result", 32'(result), 32'(expq.pop_front()));
            end
        end
    end

    // Main sequence: every channel once with a refused start, then a wrapping scan.
    initial begin
        rst_n = 1'b0;
        cmd = '0;
        volts = '0;
        mismatches = 0;
        n_checks = 0;
        seed = 32'h43f5584a;
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            volts[i] = seed[9:0];
        end
        volts[0] = 10'h000;
        volts[1] = 10'h3ff;
        volts[2] = 10'h200;
        volts[3] = 10'h1ff;
        repeat (6) @(negedge sys_clk);
        check("outputs in reset", 32'({analog, result, busy, done_irq}), 32'h0);
        rst_n = 1'b1;
        @(negedge sys_clk);
        for (int ch = 0; ch < 16; ch++) begin
            run(4'(ch), 1'b0, 1'b0, 1);
        end
        run(4'h5, 1'b0, 1'b1, 2);
        run(4'he, 1'b1, 1'b0, 4);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (80) @(negedge sys_clk);
        check("leftover results", 32'(expq.size()), 32'h0);
        check("busy after reset", 32'({busy, done_irq}), 32'h0);
        results();
    end
endmodule
